// ==== inc/strap_latch_params.svh ====
// Constants for the strap option latch
`ifndef STRAP_LATCH_PARAMS_SVH
`define STRAP_LATCH_PARAMS_SVH
`define REF_CLK_MHZ          50
`define CORE_CLK_MHZ         100
`define MGMT_ADDR_DEFAULT    3'h1
`define MGMT_ADDR_UPPER      2'h0
`define MODE_RMII            3'h1
`define MODE_RMII_B2B        3'h5
`define CTRL_BIT_DUPLEX      8
`define CTRL_BIT_ISOLATE     10
`define CTRL_BIT_AUTONEG     12
`define CTRL_BIT_SPEED       13
`define EXT_BIT_BCAST_OFF    9
`define CTRL_WIDTH           16
`endif

// ==== inc/strap_latch_pkg.sv ====
// Types for the strap option latch
package strap_latch_pkg;
    typedef enum logic [1:0] {
        ST_RESET  = 2'h0,
        ST_LATCH  = 2'h1,
        ST_RUN    = 2'h3
    } phase_t;

    typedef struct packed {
        logic       addrBit2;
        logic       addrBit1;
        logic       addrBit0;
        logic [2:0] cfgMode;
        logic       isolate;
        logic       speed;
        logic       duplex;
        logic       autoneg;
        logic       bcastOff;
        logic       nandTreeN;
    } strap_t;

    typedef struct packed {
        logic [1:0] data;
        logic       valid;
    } rmii_beat_t;
endpackage : strap_latch_pkg

// ==== hw/sync_edge.sv ====
// Two-flop synchroniser with rising edge detect
`timescale 1ns/10ps
module sync_edge
(
    input  wire logic core_clk,
    input  wire logic resetn,
    input  wire logic clkEn,
    input  wire logic asyncIn,
    output logic      syncOut,
    output logic      rise
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } sync_state_t;

    sync_state_t state_reg;
    sync_state_t state_next;

    always_comb
    begin
        state_next = state_reg;
        if (clkEn)
        begin
            state_next.meta = asyncIn;
            state_next.sync = state_reg.meta;
            state_next.prev = state_reg.sync;
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign syncOut = state_reg.sync;
    assign rise    = state_reg.sync & ~state_reg.prev;
endmodule : sync_edge

// ==== hw/strap_option_latch_rmii.sv ====
// Strap latch and RMII two-bit datapath of the transceiver
//
// Overview of operation
// - Receive: two bits per reference clock with valid
// - Transmit: take two bits per clock with enable
// - Sample all straps when reset is released
// - Straps are inputs through reset until latched, outputs after
// - Address low bits from straps, zero until latched
// - Address bits four and three are zero
// - Address zero broadcast unless strap or bit
// - Mode 001 RMII, 101 back-to-back, else reserved
// - Isolate strap into control bit ten
// - Speed strap into control and advertisement
// - Duplex strap into control bit eight
// - Autoneg strap into control bit twelve
// - Broadcast-off strap latched internally
// - NAND tree strap latched, low enables test
`timescale 1ns/10ps
`include "strap_latch_params.svh"
module strap_option_latch_rmii
(
    input  wire logic                    core_clk,
    input  wire logic                    resetn,
    input  wire logic                    clkEn,
    input  wire logic                    refClk,
    input  wire strap_latch_pkg::strap_t strapPins,
    output logic                         strapOe,
    input  wire logic [1:0]              rxRecovered,
    input  wire logic                    rxRecoveredValid,
    output logic [1:0]                   rxd,
    output logic                         crsDv,
    input  wire logic [1:0]              txd,
    input  wire logic                    txEn,
    output logic [1:0]                   txData,
    output logic                         txDataValid,
    input  wire logic                    ctrlWrite,
    input  wire logic [15:0]             ctrlWrData,
    input  wire logic                    bcastOffWrite,
    input  wire logic                    bcastOffWrData,
    output logic [15:0]                  ctrlReg,
    output logic                         advSpeed100,
    output logic [4:0]                   mgmtAddr,
    output logic                         addrZeroBroadcast,
    output logic                         modeRmii,
    output logic                         modeBackToBack,
    output logic                         modeReserved,
    output logic                         nandTreeEnable,
    output logic                         configDone
);
    typedef struct packed {
        strap_latch_pkg::phase_t     phase;
        strap_latch_pkg::strap_t     straps;
        logic [15:0]                 ctrl;
        logic                        adv100;
        logic                        bcastOffSw;
        strap_latch_pkg::rmii_beat_t rxOut;
        strap_latch_pkg::rmii_beat_t txIn;
    } latch_state_t;

    latch_state_t state_reg;
    latch_state_t state_next;

    strap_latch_pkg::strap_t strapSync;
    strap_latch_pkg::strap_t strapMeta;
    logic                    refRise;
    logic [1:0]              txdSync;
    logic [1:0]              txdMeta;
    logic                    txEnSync;
    logic                    txEnMeta;

    // Reference clock arrives from outside; find its rising edges in core domain
    sync_edge refEdge
    (
        .core_clk (core_clk),
        .resetn   (resetn),
        .clkEn    (clkEn),
        .asyncIn  (refClk),
        .syncOut  (),
        .rise     (refRise)
    );

    // Strap synchroniser runs through reset: the pin levels must
    // already sit in the second flop at the latch edge, else the
    // latch would catch the reset value instead of the board straps
    always_ff @(posedge core_clk)
    begin
        if (clkEn)
        begin
            strapMeta <= strapPins;
            strapSync <= strapMeta;
        end
    end

    // Link pins pass two flops before use
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            txdMeta   <= 2'h0;
            txdSync   <= 2'h0;
            txEnMeta  <= 1'b0;
            txEnSync  <= 1'b0;
        end
        else if (clkEn)
        begin
            txdMeta   <= txd;
            txdSync   <= txdMeta;
            txEnMeta  <= txEn;
            txEnSync  <= txEnMeta;
        end
    end

    function automatic logic [15:0] ctrl_from_straps
    (
        input strap_latch_pkg::strap_t s
    );
        logic [15:0] c;
        c = 16'h0000;
        c[`CTRL_BIT_ISOLATE] = s.isolate;
        c[`CTRL_BIT_SPEED]   = s.speed;
        c[`CTRL_BIT_DUPLEX]  = s.duplex;
        c[`CTRL_BIT_AUTONEG] = s.autoneg;
        return c;
    endfunction : ctrl_from_straps

    always_comb
    begin
        state_next = state_reg;
        if (clkEn)
        begin
            unique case (state_reg.phase)
                // Synchroniser needs two edges to carry pin levels
                strap_latch_pkg::ST_RESET:
                    state_next.phase = strap_latch_pkg::ST_LATCH;
                strap_latch_pkg::ST_LATCH:
                begin
                    state_next.straps = strapSync;
                    state_next.ctrl   = ctrl_from_straps(strapSync);
                    state_next.adv100 = strapSync.speed;
                    state_next.phase  = strap_latch_pkg::ST_RUN;
                end
                strap_latch_pkg::ST_RUN:
                begin
                    // Straps never re-sampled; only software moves bits
                    if (ctrlWrite)
                        state_next.ctrl = ctrlWrData;
                    if (bcastOffWrite)
                        state_next.bcastOffSw = bcastOffWrData;
                end
                default:
                    state_next.phase = strap_latch_pkg::ST_RESET;
            endcase
            if (refRise && state_reg.phase == strap_latch_pkg::ST_RUN)
            begin
                state_next.rxOut.data  = rxRecovered;
                state_next.rxOut.valid = rxRecoveredValid;
                state_next.txIn.data   = txdSync;
                state_next.txIn.valid  = txEnSync;
            end
            else
                state_next.txIn.valid = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    // Pins stay inputs until straps are caught, then drive
    assign strapOe     = (state_reg.phase == strap_latch_pkg::ST_RUN);
    assign configDone  = strapOe;
    assign rxd         = state_reg.rxOut.data;
    assign crsDv       = state_reg.rxOut.valid;
    assign txData      = state_reg.txIn.data;
    assign txDataValid = state_reg.txIn.valid;
    assign ctrlReg     = state_reg.ctrl;
    assign advSpeed100 = state_reg.adv100;
    // Upper address bits held at zero
    assign mgmtAddr    = {`MGMT_ADDR_UPPER, state_reg.straps.addrBit2,
                          state_reg.straps.addrBit1,
                          state_reg.straps.addrBit0};
    assign addrZeroBroadcast = ~(state_reg.straps.bcastOff
                                 | state_reg.bcastOffSw);
    assign modeRmii       = (state_reg.straps.cfgMode == `MODE_RMII);
    assign modeBackToBack = (state_reg.straps.cfgMode == `MODE_RMII_B2B);
    assign modeReserved   = strapOe & ~modeRmii & ~modeBackToBack;
    assign nandTreeEnable = strapOe & ~state_reg.straps.nandTreeN;

    AST_LATCH_ONCE: assert property (@(posedge core_clk) disable iff (!resetn)
        clkEn && state_reg.phase == strap_latch_pkg::ST_LATCH
        |=> state_reg.straps == $past(strapSync))
        else $error("straps not latched at release");
    AST_STRAPS_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
        $past(strapOe) |-> $stable(state_reg.straps))
        else $error("latched straps changed");
    AST_OE_AFTER_RESET: assert property (@(posedge core_clk)
        disable iff (!resetn)
        $rose(strapOe) |-> $past(state_reg.phase) ==
            strap_latch_pkg::ST_LATCH)
        else $error("strap drive before latch");
    AST_ADDR_UPPER: assert property (@(posedge core_clk) disable iff (!resetn)
        mgmtAddr[4:3] == 2'h0)
        else $error("upper address bits not zero");
    AST_ADDR_LOW: assert property (@(posedge core_clk) disable iff (!resetn)
        strapOe |-> mgmtAddr[2:0] == {state_reg.straps.addrBit2,
            state_reg.straps.addrBit1, state_reg.straps.addrBit0})
        else $error("address not from straps");
    AST_BCAST: assert property (@(posedge core_clk) disable iff (!resetn)
        strapOe && state_reg.straps.bcastOff |-> !addrZeroBroadcast)
        else $error("broadcast kept with strap high");
    AST_BCAST_SW: assert property (@(posedge core_clk) disable iff (!resetn)
        clkEn && strapOe && bcastOffWrite && bcastOffWrData
        |=> !addrZeroBroadcast)
        else $error("software broadcast off ignored");
    AST_MODE: assert property (@(posedge core_clk) disable iff (!resetn)
        strapOe |-> $onehot({modeRmii, modeBackToBack, modeReserved}))
        else $error("mode decode not exclusive");
    AST_CTRL_INIT: assert property (@(posedge core_clk) disable iff (!resetn)
        $rose(strapOe) |-> ctrlReg[`CTRL_BIT_SPEED] == advSpeed100
        && ctrlReg[`CTRL_BIT_AUTONEG] == state_reg.straps.autoneg
        && ctrlReg[`CTRL_BIT_DUPLEX] == state_reg.straps.duplex
        && ctrlReg[`CTRL_BIT_ISOLATE] == state_reg.straps.isolate)
        else $error("control bits not from straps");
    AST_NAND: assert property (@(posedge core_clk) disable iff (!resetn)
        nandTreeEnable |-> !state_reg.straps.nandTreeN)
        else $error("nand tree enabled with strap high");
    AST_TX_BEAT: assert property (@(posedge core_clk) disable iff (!resetn)
        clkEn && refRise && strapOe && txEnSync
        |=> txDataValid && txData == $past(txdSync))
        else $error("tx beat lost");
    AST_RX_BEAT: assert property (@(posedge core_clk) disable iff (!resetn)
        clkEn && refRise && strapOe
        |=> crsDv == $past(rxRecoveredValid) && rxd == $past(rxRecovered))
        else $error("rx beat not driven");

    // Release walk: one enabled edge to arm, one to catch the pins
    sequence s_arm;
        clkEn && state_reg.phase == strap_latch_pkg::ST_RESET;
    endsequence

    sequence s_catch;
        clkEn && state_reg.phase == strap_latch_pkg::ST_LATCH;
    endsequence

    sequence s_beat_edge;
        clkEn && refRise && strapOe;
    endsequence

    AST_RELEASE_WALK: assert property (@(posedge core_clk)
        disable iff (!resetn)
        s_arm ##1 s_catch |=> strapOe)
        else $error("release walk did not reach drive");
    AST_FREEZE: assert property (@(posedge core_clk) disable iff (!resetn)
        !clkEn |=> $stable(state_reg))
        else $error("state moved while clock enable low");
    AST_TX_IDLE: assert property (@(posedge core_clk) disable iff (!resetn)
        clkEn && !refRise |=> !txDataValid)
        else $error("tx valid without reference edge");
    AST_RX_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
        clkEn && !refRise |=> $stable(rxd) && $stable(crsDv))
        else $error("rx output moved between reference edges");
    AST_RX_SEQ: assert property (@(posedge core_clk) disable iff (!resetn)
        s_beat_edge |=> crsDv == $past(rxRecoveredValid))
        else $error("rx valid not taken at reference edge");
    AST_CTRL_WRITE: assert property (@(posedge core_clk)
        disable iff (!resetn)
        clkEn && strapOe && ctrlWrite |=> ctrlReg == $past(ctrlWrData))
        else $error("control write not applied");
    AST_ADV_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
        strapOe && $past(strapOe) |-> $stable(advSpeed100))
        else $error("advertised speed changed after latch");
endmodule : strap_option_latch_rmii

// ==== testbench/rmii_mac_model.sv ====
// Behavioural RMII MAC with free-running reference clock
`timescale 1ns/10ps
module rmii_mac_model
(
    output logic            refClk,
    output logic [1:0]      txd,
    output logic            txEn,
    input  wire logic [1:0] rxd,
    input  wire logic       crsDv
);
    logic [1:0] rxq[$];
    initial
    begin
        refClk = 1'b0;
        txd = 2'h0;
        txEn = 1'b0;
        forever #62.5 refClk = ~refClk;
    end
    // Mid-period sample keeps clear of the core-side launch
    always @(negedge refClk)
        if (crsDv === 1'b1)
            rxq.push_back(rxd);
    task automatic send(input int n);
        for (int i = 0; i < n; i++)
        begin
            @(negedge refClk);
            txd <= i[1:0];
            txEn <= 1'b1;
        end
        @(negedge refClk);
        txEn <= 1'b0;
        txd <= 2'h0;
    endtask : send
endmodule : rmii_mac_model

// ==== testbench/tb_top.sv ====
// Self-checking bench for the strap option latch
`timescale 1ns/10ps
`include "strap_latch_params.svh"
module tb_top;
    logic core_clk, resetn, refClk, txEn, txDataValid, crsDv;
    logic rxRecoveredValid, ctrlWrite, bcastOffWrite, bcastOffWrData;
    logic strapOe, advSpeed100, addrZeroBroadcast, configDone;
    logic modeRmii, modeBackToBack, modeReserved, nandTreeEnable;
    logic [1:0]  rxRecovered, rxd, txd, txData;
    logic [15:0] ctrlWrData, ctrlReg;
    logic [4:0]  mgmtAddr;
    logic [1:0]  txq[$];
    strap_latch_pkg::strap_t strapPins;
    strap_latch_pkg::strap_t cases[4] = '{12'h25D, 12'h162, 12'h095, 12'hFFF};
    logic clkEn = 1'b1;
    int bad_count = 0;
    int checks_done = 0;

    strap_option_latch_rmii dut (.core_clk(core_clk), .resetn(resetn),
        .clkEn(clkEn), .refClk(refClk), .strapPins(strapPins),
        .strapOe(strapOe), .rxRecovered(rxRecovered),
        .rxRecoveredValid(rxRecoveredValid), .rxd(rxd), .crsDv(crsDv),
        .txd(txd), .txEn(txEn), .txData(txData), .txDataValid(txDataValid),
        .ctrlWrite(ctrlWrite), .ctrlWrData(ctrlWrData),
        .bcastOffWrite(bcastOffWrite), .bcastOffWrData(bcastOffWrData),
        .ctrlReg(ctrlReg), .advSpeed100(advSpeed100), .mgmtAddr(mgmtAddr),
        .addrZeroBroadcast(addrZeroBroadcast), .modeRmii(modeRmii),
        .modeBackToBack(modeBackToBack), .modeReserved(modeReserved),
        .nandTreeEnable(nandTreeEnable), .configDone(configDone));
    rmii_mac_model mac (.refClk(refClk), .txd(txd), .txEn(txEn),
        .rxd(rxd), .crsDv(crsDv));

    // Sample mid-cycle, clear of the edge that launches the pulse
    always @(negedge core_clk)
        if (txDataValid === 1'b1)
            txq.push_back(txData);

    task automatic check_vec(input string what, input logic [15:0] e, g);
        checks_done++;
        if (g !== e)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : check_vec

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    task automatic boot(input strap_latch_pkg::strap_t s);
        @(negedge core_clk);
        resetn = 1'b0;
        strapPins = s;
        repeat (10) @(negedge core_clk);
        check_vec("strapOe in reset", 16'h0, {15'h0, strapOe});
        resetn = 1'b1;
        repeat (6) @(negedge core_clk);
    endtask : boot

    task automatic verify(input strap_latch_pkg::strap_t s);
        logic [15:0] c;
        c = {2'h0, s.speed, s.autoneg, 1'b0, s.isolate, 1'b0, s.duplex, 8'h0};
        check_vec("ctrlReg", c, ctrlReg);
        check_vec("advSpeed100", {15'h0, s.speed}, advSpeed100);
        check_vec("mgmtAddr", {13'h0, s[11:9]}, mgmtAddr);
        check_vec("modeRmii", s.cfgMode == `MODE_RMII, modeRmii);
        check_vec("modeB2b", s.cfgMode == `MODE_RMII_B2B, modeBackToBack);
        check_vec("modeRes", s.cfgMode != `MODE_RMII &&
            s.cfgMode != `MODE_RMII_B2B, modeReserved);
        check_vec("nandTree", {15'h0, ~s.nandTreeN}, nandTreeEnable);
        check_vec("strapOe", 16'h1, {15'h0, strapOe});
        check_vec("configDone", 16'h1, {15'h0, configDone});
        if (s[11:9] == 3'h0)
            check_vec("bcast", {15'h0, ~s.bcastOff}, addrZeroBroadcast);
    endtask : verify

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial
    begin
        #100000;
        bad_count++;
        report_and_stop();
    end

    initial
    begin
        resetn = 1'b0;
        strapPins = cases[0];
        {rxRecovered, rxRecoveredValid, ctrlWrite, ctrlWrData} = '0;
        {bcastOffWrite, bcastOffWrData} = 2'h0;
        for (int k = 0; k < 4; k++)
        begin
            boot(cases[k]);
            verify(cases[k]);
            if (k == 0)
            begin
                // Pins flip after latch; outputs must not follow
                strapPins = ~cases[0];
                repeat (5) @(negedge core_clk);
                verify(cases[0]);
                ctrlWrite = 1'b1;
                ctrlWrData = 16'hC3A5;
                @(negedge core_clk);
                ctrlWrite = 1'b0;
                check_vec("ctrlReg write", 16'hC3A5, ctrlReg);
                txq.delete();
                fork
                    mac.send(8);
                    for (int i = 0; i < 9; i++)
                    begin
                        @(negedge refClk);
                        @(negedge core_clk);
                        rxRecovered = ~i[1:0];
                        rxRecoveredValid = (i < 8);
                    end
                join
                repeat (40) @(negedge core_clk);
                check_vec("tx count", 16'd8, txq.size());
                check_vec("rx count", 16'd8, mac.rxq.size());
                for (int i = 0; i < 8 && i < txq.size(); i++)
                    check_vec("txData", {14'h0, i[1:0]}, txq[i]);
                for (int i = 0; i < 8 && i < mac.rxq.size(); i++)
                    check_vec("rxd", {14'h0, ~i[1:0]}, mac.rxq[i]);
            end
            if (k == 2)
            begin
                bcastOffWrite = 1'b1;
                bcastOffWrData = 1'b1;
                @(negedge core_clk);
                bcastOffWrite = 1'b0;
                @(negedge core_clk);
                check_vec("bcast sw", 16'h0, addrZeroBroadcast);
            end
            if (k == 3)
            begin
                // Frozen block must ignore a write pulse
                clkEn = 1'b0;
                ctrlWrite = 1'b1;
                ctrlWrData = 16'h1234;
                @(negedge core_clk);
                ctrlWrite = 1'b0;
                clkEn = 1'b1;
                @(negedge core_clk);
                verify(cases[3]);
            end
        end
        report_and_stop();
    end
endmodule : tb_top
